// ---- dac_cfg_defines.svh ----
// Register indices, reset values and field positions of the converter control bank.
// Assumes word-aligned 32-bit AHB-Lite access; byte address is four times the index.
`ifndef DAC_CFG_DEFINES_SVH
`define DAC_CFG_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define IDX_POWER_CONFIG 6'h03
`define IDX_GAIN_CONFIG 6'h04
`define IDX_REF_STATUS 6'h07
`define IDX_IRQ_STATUS 6'h10
`define IDX_IRQ_MASK 6'h11

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define POWER_CONFIG_RESET 16'h0000
`define GAIN_CONFIG_RESET 16'h0001
`define IRQ_RESET 2'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define REF_OFF_BIT 8
`define POWERDOWN_BIT 0
`define REF_HALF_BIT 8
`define GAIN_DOUBLE_BIT 0
`define ALARM_BIT 0
`define EV_ALARM_ON 0
`define EV_ALARM_OFF 1

// ----------------------------------------------------------------
// Bus decode
// ----------------------------------------------------------------
`define HSIZE_WORD 3'h2

`endif

// ---- dac_cfg_pkg.sv ----
// Types shared by the register front end and the register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package dac_cfg_pkg;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    // Bus front-end phases
    typedef enum logic [1:0] {
        FR_IDLE = 2'b00,
        FR_WRITE = 2'b01,
        FR_RLOAD = 2'b10,
        FR_RDONE = 2'b11
    } front_state_e;

    // One control register
    typedef logic [15:0] reg16_t;

    // Word index on the bus
    typedef logic [5:0] word_idx_t;

endpackage : dac_cfg_pkg

// ---- reg_access_if.sv ----
// Carries decoded register accesses from the bus front end to the bank.
// Assumes both ends run on the same hclk.
`timescale 1ns/1ps
interface reg_access_if;
    import dac_cfg_pkg::*;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic wr_en; // One-cycle write strobe
    word_idx_t idx; // Word index of the access
    logic [31:0] wdata; // Write data
    logic [31:0] rdata; // Read data for idx

    modport front (output wr_en, output idx, output wdata, input rdata);
    modport bank (input wr_en, input idx, input wdata, output rdata);
endinterface : reg_access_if

// ---- ahb_reg_front.sv ----
// AHB-Lite slave front end: captures the address phase, strobes writes,
// and holds one wait state on reads so read data come from a flop.
// Assumes a single slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module ahb_reg_front
    import dac_cfg_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Register bank side
    reg_access_if.front regs
);
    `include "dac_cfg_defines.svh"

    front_state_e state_q, state_d; // Phase tracker
    word_idx_t idx_q, idx_d; // Captured index
    logic ok_q, ok_d; // Mapped, word-sized access
    logic [31:0] hrdata_q, hrdata_d; // Registered read data
    logic accept; // Address phase taken

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // NONSEQ and SEQ both start a transfer
    assign accept = hsel && htrans[1] && hready;

    always_comb begin
        state_d = FR_IDLE;
        idx_d = idx_q;
        ok_d = ok_q;
        hrdata_d = hrdata_q;
        unique case (state_q)
            FR_IDLE: state_d = FR_IDLE;
            FR_WRITE: state_d = FR_IDLE;
            // Wait cycle: load read data so a just-written value is seen
            FR_RLOAD: begin
                hrdata_d = ok_q ? regs.rdata : 32'h0000_0000;
                state_d = FR_RDONE;
            end
            FR_RDONE: state_d = FR_IDLE;
        endcase
        if (accept) begin
            idx_d = haddr[7:2];
            // Unmapped or narrow access: write ignored, read returns zero
            ok_d = (haddr[31:8] == 24'h00_0000) && (hsize == `HSIZE_WORD);
            state_d = hwrite ? FR_WRITE : FR_RLOAD;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= FR_IDLE;
            idx_q <= 6'h00;
            ok_q <= 1'b0;
            hrdata_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            ok_q <= ok_d;
            hrdata_q <= hrdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign hreadyout = (state_q != FR_RLOAD); // One wait state on reads
    assign hresp = 1'b0; // Always OKAY
    assign hrdata = hrdata_q;
    assign regs.wr_en = (state_q == FR_WRITE) && ok_q;
    assign regs.idx = idx_q;
    assign regs.wdata = hwdata;

    // Read holds exactly one wait state
    property p_read_wait;
        @(posedge hclk) disable iff (!hresetn)
        (state_q == FR_RLOAD) |-> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

endmodule : ahb_reg_front

// ---- dac_power_gain_config_regs.sv ----
// Power and gain control register bank of a voltage-output converter,
// with reference alarm status and a maskable interrupt.
// Assumes an AHB-Lite master on hclk and an async comparator alarm level.
`timescale 1ns/1ps
module dac_power_gain_config_regs
    import dac_cfg_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Analog comparator
    input wire logic ref_alarm_in,
    // Analog controls
    output logic internal_ref_off,
    output logic output_powerdown,
    output logic ref_half,
    output logic output_gain_double,
    output logic ref_buffer_off,
    output logic output_zero,
    // Interrupt
    output logic irq
);
    `include "dac_cfg_defines.svh"

    // ----------------------------------------------------------------
    // Bus front end
    // ----------------------------------------------------------------
    reg_access_if bus_if ();

    ahb_reg_front u_front (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .regs(bus_if.front)
    );

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg16_t power_config_q, power_config_d; // Power-down controls
    reg16_t gain_config_q, gain_config_d; // Divider and gain controls
    logic [1:0] irq_status_q, irq_status_d; // Sticky events
    logic [1:0] irq_mask_q, irq_mask_d; // Event enables
    logic alarm_meta_q; // First sync stage, read only by stage two
    logic alarm_s_q; // Synchronised alarm
    logic alarm_prev_q; // For edge detection
    logic [1:0] events; // Alarm on / off pulses
    logic wr_pwr, wr_gain, wr_istat, wr_imask; // Write decodes

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    assign wr_pwr = bus_if.wr_en && (bus_if.idx == `IDX_POWER_CONFIG);
    assign wr_gain = bus_if.wr_en && (bus_if.idx == `IDX_GAIN_CONFIG);
    assign wr_istat = bus_if.wr_en && (bus_if.idx == `IDX_IRQ_STATUS);
    assign wr_imask = bus_if.wr_en && (bus_if.idx == `IDX_IRQ_MASK);

    // ----------------------------------------------------------------
    // Control registers next value
    // ----------------------------------------------------------------
    // Reserved bits are read/write storage, so all 16 bits are kept.
    // The alarm never enters here, so codes survive an alarm.
    always_comb begin
        power_config_d = power_config_q;
        gain_config_d = gain_config_q;
        irq_mask_d = irq_mask_q;
        if (wr_pwr) begin
            power_config_d = bus_if.wdata[15:0];
        end
        if (wr_gain) begin
            gain_config_d = bus_if.wdata[15:0];
        end
        if (wr_imask) begin
            irq_mask_d = bus_if.wdata[1:0];
        end
    end

    // Control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_config_q <= `POWER_CONFIG_RESET;
            gain_config_q <= `GAIN_CONFIG_RESET;
            irq_mask_q <= `IRQ_RESET;
        end else begin
            power_config_q <= power_config_d;
            gain_config_q <= gain_config_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // ----------------------------------------------------------------
    // Alarm synchroniser
    // ----------------------------------------------------------------
    // Status and events use the synchronised copy; the comparator is
    // asynchronous and would otherwise go metastable here.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_meta_q <= 1'b0;
            alarm_s_q <= 1'b0;
            alarm_prev_q <= 1'b0;
        end else begin
            alarm_meta_q <= ref_alarm_in;
            alarm_s_q <= alarm_meta_q;
            alarm_prev_q <= alarm_s_q;
        end
    end

    // Edge pulses of the synchronised alarm
    assign events[`EV_ALARM_ON] = alarm_s_q && !alarm_prev_q;
    assign events[`EV_ALARM_OFF] = !alarm_s_q && alarm_prev_q;

    // ----------------------------------------------------------------
    // Interrupt status, one slice per event
    // ----------------------------------------------------------------
    // Set wins over a write-one-to-clear in the same cycle.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_irq
            always_comb begin
                irq_status_d[gi] = irq_status_q[gi];
                if (wr_istat && bus_if.wdata[gi]) begin
                    irq_status_d[gi] = 1'b0;
                end
                if (events[gi]) begin
                    irq_status_d[gi] = 1'b1;
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    irq_status_q[gi] <= 1'b0;
                end else begin
                    irq_status_q[gi] <= irq_status_d[gi];
                end
            end
        end
    endgenerate

    // Level interrupt while any unmasked bit is set
    assign irq = |(irq_status_q & irq_mask_q);

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // Unlisted indices read zero; upper half-word always zero.
    always_comb begin
        bus_if.rdata = 32'h0000_0000;
        unique case (bus_if.idx)
            `IDX_POWER_CONFIG: bus_if.rdata[15:0] = power_config_q;
            `IDX_GAIN_CONFIG: bus_if.rdata[15:0] = gain_config_q;
            `IDX_REF_STATUS: bus_if.rdata[`ALARM_BIT] = alarm_s_q;
            `IDX_IRQ_STATUS: bus_if.rdata[1:0] = irq_status_q;
            `IDX_IRQ_MASK: bus_if.rdata[1:0] = irq_mask_q;
            default: bus_if.rdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // Analog control outputs
    // ----------------------------------------------------------------
    assign internal_ref_off = power_config_q[`REF_OFF_BIT];
    assign output_powerdown = power_config_q[`POWERDOWN_BIT];
    // Software should avoid settings that trip the alarm
    assign ref_half = gain_config_q[`REF_HALF_BIT];
    assign output_gain_double = gain_config_q[`GAIN_DOUBLE_BIT];
    // Direct analog path: no clock delay, so the output is
    // forced to zero as soon as the comparator fires.
    assign ref_buffer_off = ref_alarm_in;
    assign output_zero = ref_alarm_in;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_pwr_reset;
        @(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> (power_config_q == 16'h0000);
    endproperty
    a_pwr_reset: assert property (p_pwr_reset) else $error("power config reset wrong");

    property p_ref_off;
        @(posedge hclk) disable iff (!hresetn)
        wr_pwr |=> (internal_ref_off == $past(bus_if.wdata[8]));
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("ref off not from write");

    property p_powerdown;
        @(posedge hclk) disable iff (!hresetn)
        wr_pwr |=> (output_powerdown == $past(bus_if.wdata[0]));
    endproperty
    a_powerdown: assert property (p_powerdown) else $error("powerdown not from write");

    // Back-to-back writes are legal, so hold is checked per cycle
    property p_powerdown_hold;
        @(posedge hclk) disable iff (!hresetn)
        !wr_pwr |=> $stable(output_powerdown);
    endproperty
    a_powerdown_hold: assert property (p_powerdown_hold) else $error("powerdown changed without write");

    property p_gain_reset;
        @(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> (gain_config_q == 16'h0001) && output_gain_double;
    endproperty
    a_gain_reset: assert property (p_gain_reset) else $error("gain reset wrong");

    property p_ref_half;
        @(posedge hclk) disable iff (!hresetn)
        wr_gain |=> (ref_half == $past(bus_if.wdata[8]));
    endproperty
    a_ref_half: assert property (p_ref_half) else $error("ref half not from write");

    property p_alarm_zero;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |-> (output_zero == ref_alarm_in) && (ref_buffer_off == ref_alarm_in);
    endproperty
    a_alarm_zero: assert property (p_alarm_zero) else $error("alarm controls wrong");

    property p_codes_kept;
        @(posedge hclk) disable iff (!hresetn)
        (alarm_s_q && !bus_if.wr_en) |=> $stable(power_config_q) && $stable(gain_config_q);
    endproperty
    a_codes_kept: assert property (p_codes_kept) else $error("alarm changed registers");

    property p_gain_double;
        @(posedge hclk) disable iff (!hresetn)
        wr_gain |=> (output_gain_double == $past(bus_if.wdata[0]));
    endproperty
    a_gain_double: assert property (p_gain_double) else $error("gain not from write");

    property p_status_sync;
        @(posedge hclk) disable iff (!hresetn)
        ##2 (alarm_s_q == $past(ref_alarm_in, 2));
    endproperty
    a_status_sync: assert property (p_status_sync) else $error("status lags alarm wrongly");

    property p_irq_set;
        @(posedge hclk) disable iff (!hresetn)
        (events[0] && irq_mask_q[0] && !wr_imask) |=> irq;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq missing after alarm");

    // Main scenarios
    c_alarm_rise: cover property (@(posedge hclk) disable iff (!hresetn) $rose(alarm_s_q));
    c_pwr_write: cover property (@(posedge hclk) disable iff (!hresetn) wr_pwr);
    c_gain_write: cover property (@(posedge hclk) disable iff (!hresetn) wr_gain ##1 alarm_s_q);
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));

endmodule : dac_power_gain_config_regs

// ---- dac_power_gain_config_regs_bench.sv ----
// Self-checking bench for the converter power and gain control bank.
// Assumes one AHB-Lite slave whose hreadyout feeds back as hready.
`timescale 1ns/1ps
`include "dac_cfg_defines.svh"
module dac_power_gain_config_regs_bench
    import dac_cfg_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam logic [31:0] A_PC = {24'h00_0000, `IDX_POWER_CONFIG, 2'b00}; // Power config
    localparam logic [31:0] A_GC = {24'h00_0000, `IDX_GAIN_CONFIG, 2'b00}; // Gain config
    localparam logic [31:0] A_ST = {24'h00_0000, `IDX_REF_STATUS, 2'b00}; // Alarm status
    localparam logic [31:0] A_IS = {24'h00_0000, `IDX_IRQ_STATUS, 2'b00}; // Sticky events
    localparam logic [31:0] A_IM = {24'h00_0000, `IDX_IRQ_MASK, 2'b00}; // Event mask
    logic hclk = 1'b0; // Bus clock
    logic hresetn = 1'b0; // Reset, low active
    logic hsel = 1'b0; // Slave select
    logic hwrite = 1'b0; // Direction
    logic ref_alarm_in = 1'b0; // Comparator stand-in
    logic [1:0] htrans = 2'h0; // Transfer type
    logic [2:0] hsize = 3'h2; // Transfer size
    logic [31:0] haddr = 32'h0000_0000; // Byte address
    logic [31:0] hwdata = 32'h0000_0000; // Write data
    logic [31:0] hrdata; // Read data
    logic [31:0] rd_s; // Read data seen at the sampling edge
    logic [31:0] d; // Scratch word
    logic hreadyout, hresp, irq; // Bus and interrupt outputs
    logic internal_ref_off, output_powerdown, ref_half, output_gain_double; // Register driven controls
    logic ref_buffer_off, output_zero; // Alarm driven controls
    reg16_t pc_m, gc_m; // Expected register contents
    logic [1:0] is_m; // Expected sticky events
    int fails = 0; // Mismatches
    int checks_done = 0; // Comparisons
    logic [31:0] addrs [6] = '{A_PC, A_GC, A_ST, 32'h0000_0000, 32'h0000_0014, 32'h0000_00fc}; // Random targets
    logic [31:0] corner [4] = '{32'hffff_ffff, 32'h0000_0100, 32'h0000_0001, 32'h0000_0000}; // Edge words

    always #5 hclk = ~hclk; // 100 MHz

    // ----------------------------------------------------------------
    // Design
    // ----------------------------------------------------------------
    dac_power_gain_config_regs DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ref_alarm_in(ref_alarm_in),
        .internal_ref_off(internal_ref_off), .output_powerdown(output_powerdown),
        .ref_half(ref_half), .output_gain_double(output_gain_double),
        .ref_buffer_off(ref_buffer_off), .output_zero(output_zero), .irq(irq)
    );

    // ----------------------------------------------------------------
    // Compare and close
    // ----------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin // Four-state compare, an unknown matches only an unknown in the same bit
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic close_out();
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------------------------------
    // Bus master
    // ----------------------------------------------------------------
    // Ready is looked at on the falling edge, where it is settled and equals what the next rising edge samples
    task automatic wait_rdy();
        int n;
        n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(negedge hclk);
        end
        if (n >= 50) begin // Stuck slave
            fails++;
            close_out();
        end
        rd_s = hrdata;
        @(posedge hclk);
    endtask : wait_rdy

    // One single transfer; entered right after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, input logic [2:0] sz);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= sz;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        if (wr) hwdata <= wd;
        wait_rdy();
        if (wr && sz == 3'h2 && a == A_PC) pc_m = wd[15:0]; // Only word writes land
        if (wr && sz == 3'h2 && a == A_GC) gc_m = wd[15:0];
        if (wr && sz == 3'h2 && a == A_IS) is_m = is_m & ~wd[1:0]; // Write one clears
    endtask : bus

    // ----------------------------------------------------------------
    // Expectations
    // ----------------------------------------------------------------
    function automatic logic [31:0] exp_rd(input logic [31:0] a, input logic alarm);
        case (a)
            A_PC: exp_rd = {16'h0000, pc_m};
            A_GC: exp_rd = {16'h0000, gc_m};
            A_ST: exp_rd = {31'h0000_0000, alarm};
            A_IS: exp_rd = {30'h0000_0000, is_m};
            default: exp_rd = 32'h0000_0000; // Unmapped reads zero
        endcase
    endfunction : exp_rd

    // Control pins, checked where settled
    task automatic chk_ctl();
        @(negedge hclk);
        chk_word({27'h000_0000, hresp, internal_ref_off, output_powerdown, ref_half, output_gain_double},
            {27'h000_0000, 1'b0, pc_m[8], pc_m[0], gc_m[8], gc_m[0]});
        @(posedge hclk);
    endtask : chk_ctl

    // Interrupt pin, checked where settled, not in the edge that moves it
    task automatic chk_irq(input logic exp);
        @(negedge hclk);
        chk_bit(irq, exp);
        @(posedge hclk);
    endtask : chk_irq

    // Read one place and compare with the model
    task automatic rd_chk(input logic [31:0] a, input logic alarm);
        bus(1'b0, a, 32'h0000_0000, 3'h2);
        chk_word(rd_s, exp_rd(a, alarm));
    endtask : rd_chk

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h8591cd9d));
        pc_m = 16'h0000;
        gc_m = 16'h0001;
        is_m = 2'b00;
        repeat (4) @(posedge hclk);
        chk_ctl();
        hresetn <= 1'b1;
        rd_chk(A_PC, 1'b0);
        rd_chk(A_GC, 1'b0);
        // Corner words, upper half must read back zero
        foreach (corner[i]) begin
            bus(1'b1, A_PC, corner[i], 3'h2);
            bus(1'b1, A_GC, corner[3 - i], 3'h2);
            rd_chk(A_PC, 1'b0);
            rd_chk(A_GC, 1'b0);
            chk_ctl();
        end
        // Random traffic, some of it unmapped, read-only or not word sized
        for (int i = 0; i < 40; i++) begin
            d = addrs[$urandom_range(0, 5)];
            bus(1'b1, d, $urandom, ($urandom_range(0, 5) == 0) ? 3'h1 : 3'h2);
            rd_chk(d, 1'b0);
            chk_ctl();
        end
        // Alarm raised with both events unmasked
        bus(1'b1, A_IM, 32'h0000_0003, 3'h2);
        ref_alarm_in <= 1'b1;
        @(negedge hclk);
        chk_bit(output_zero, 1'b1);
        chk_bit(ref_buffer_off, 1'b1);
        repeat (4) @(posedge hclk);
        is_m = is_m | 2'b01; // Alarm rose
        rd_chk(A_ST, 1'b1);
        rd_chk(A_PC, 1'b1);
        rd_chk(A_GC, 1'b1);
        chk_ctl();
        chk_irq(1'b1);
        rd_chk(A_IS, 1'b0);
        chk_word(rd_s, 32'h0000_0001);
        bus(1'b1, A_IS, 32'h0000_0001, 3'h2);
        bus(1'b0, A_IS, 32'h0000_0000, 3'h2);
        chk_word(rd_s, 32'h0000_0000);
        chk_irq(1'b0);
        // Alarm released, output comes back from retained settings
        ref_alarm_in <= 1'b0; // Divider corrected, comparator clears
        @(negedge hclk);
        chk_bit(output_zero, 1'b0);
        chk_bit(ref_buffer_off, 1'b0);
        repeat (4) @(posedge hclk);
        is_m = is_m | 2'b10; // Alarm fell
        rd_chk(A_ST, 1'b0);
        bus(1'b0, A_IS, 32'h0000_0000, 3'h2);
        chk_word(rd_s, 32'h0000_0002);
        chk_irq(1'b1);
        // Masking hides a pending event, clearing removes it
        bus(1'b1, A_IM, 32'h0000_0000, 3'h2);
        chk_irq(1'b0);
        bus(1'b1, A_IS, 32'h0000_0002, 3'h2);
        bus(1'b0, A_IS, 32'h0000_0000, 3'h2);
        chk_word(rd_s, 32'h0000_0000);
        close_out();
    end

    // Whole run is well under 2000 cycles; a hang ends here
    initial begin
        #100000;
        fails++;
        close_out();
    end
endmodule : dac_power_gain_config_regs_bench
